// *** hdl/pvf_formatter.sv ***
// Vector packet formatter: turns decoded short message and long data
// vectors into 32-bit packets, followed by the long-address message
// packet where one is due. Registers sit on a classic Wishbone slave.
// Assumes vector input and packet sink run on mclk.
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
module pvf_formatter
   import pvf_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        nrst,
   // Decoded vector input
   input  wire logic        vecValid,
   input  wire pvf_vec_t    vecIn,
   output logic             vecReady,
   // Packet output to host transport
   output logic             pktValid,
   input  wire logic        pktReady,
   output logic [31:0]      pktData,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // Status
   output logic             allFrameMode
);

   // ***********************************************************
   // Packet builders
   // ***********************************************************
   function automatic logic [11:0] shortData(input logic [1:0]  mt,
                                             input logic [11:0] d);
      logic [11:0] r;
      r = d;
      case (mt)
         MT_TONE8: r = d & MASK_TONE8;
         MT_TONEN: r = d & MASK_TONEN;
         MT_NUM:   r = d;
         default:  r = d;
      endcase
      return r;
   endfunction : shortData

   function automatic logic longInvalid(input pvf_vec_t v);
      return (v.wordCount < CNT_MIN) || (v.wordCount > CNT_MAX) ||
             (v.startWord < START_MIN) || (v.startWord > START_MAX);
   endfunction : longInvalid

   pvf_state_t s;
   pvf_state_t n;
   logic       isShort;
   logic       isLong;
   logic       wordNumOk;
   logic       errFlag;
   logic       take;
   logic       wbReq;
   logic [31:0] vecPkt;
   logic [31:0] msgPkt;
   logic [20:0] msgBits;

   // ***********************************************************
   // Vector classification
   // ***********************************************************
   always_comb begin
      isShort = (vecIn.vType == VT_SHORT);
      isLong  = (vecIn.vType == VT_SECURE) || (vecIn.vType == VT_ALPHA) ||
                (vecIn.vType == VT_HEXBIN);
      wordNumOk = (vecIn.vectorWordNumber >= WORDNO_MIN) &&
                  (vecIn.vectorWordNumber <= WORDNO_MAX);
      errFlag = vecIn.bitErrs | vecIn.checkFail;
      if (isLong) begin
         errFlag = errFlag | longInvalid(vecIn);
      end
   end

   // ***********************************************************
   // Packet assembly
   // ***********************************************************
   always_comb begin
      vecPkt = 32'h0000_0000;
      vecPkt[WORDNO_LSB +: 7] = vecIn.vectorWordNumber;
      vecPkt[ERR_BIT]      = errFlag;
      vecPkt[PH_LSB +: 2]  = vecIn.phase;
      vecPkt[VT_LSB +: 3]  = vecIn.vType;
      if (isShort) begin
         vecPkt[DATA_LSB +: 12] = shortData(vecIn.msgType, vecIn.data);
         vecPkt[1:0]            = vecIn.msgType;
      end else begin
         vecPkt[CNT_LSB +: 7] = vecIn.wordCount;
         vecPkt[6:0]          = vecIn.startWord;
      end
      if (isShort && !((vecIn.msgType == MT_NUM) && !vecIn.netAddr)) begin
         msgBits = '0;
      end else begin
         msgBits = vecIn.msgInfo;
      end
      msgPkt = 32'h0000_0000;
      msgPkt[WORDNO_LSB +: 7] = vecIn.vectorWordNumber + WORDNO_STEP;
      msgPkt[ERR_BIT]     = vecIn.msgErr;
      msgPkt[PH_LSB +: 2] = vecIn.phase;
      msgPkt[0 +: INFO_W] = msgBits;
   end

   // ***********************************************************
   // Next state
   // ***********************************************************
   always_comb begin
      n        = s;
      vecReady = s.enable && (s.st == ST_IDLE);
      take     = vecValid && vecReady;
      wbReq    = cyc_i && stb_i && !s.ack;
      n.ack    = wbReq;
      case (s.st)
         ST_IDLE: begin
            if (take) begin
               if (!wordNumOk || !(isShort || isLong)) begin
                  if (s.dropCnt != DROP_MAX) begin
                     n.dropCnt = s.dropCnt + DROP_ONE;
                  end
               end else begin
                  n.st      = ST_VEC;
                  n.pkt     = vecPkt;
                  n.msg     = msgPkt;
                  n.lastVec = vecPkt;
                  n.sendMsg = vecIn.longAddr && !errFlag;
               end
            end
         end
         ST_VEC: begin
            if (pktReady) begin
               if (s.sendMsg) begin
                  n.st  = ST_MSG;
                  n.pkt = s.msg;
               end else begin
                  n.st = ST_IDLE;
               end
            end
         end
         ST_MSG: begin
            if (pktReady) begin
               n.st = ST_IDLE;
            end
         end
         default: n.st = ST_IDLE;
      endcase
      // Register writes commit on the acknowledge edge
      if (cyc_i && stb_i && s.ack && we_i && sel_i[0]) begin
         if (adr_i == REG_CTRL) begin
            n.enable = dat_i[0];
         end
         if ((adr_i == REG_AFMCLR) && dat_i[0]) begin
            n.afm = 1'b0;
         end
      end
      if (take && wordNumOk && isLong) begin
         n.afm = 1'b1;
      end
      // Register reads
      if (wbReq && !we_i) begin
         case (adr_i)
            REG_CTRL:    n.rdat = {31'h0000_0000, s.enable};
            REG_STATUS:  n.rdat = {30'h0000_0000,
                                   s.st != ST_IDLE, s.afm};
            REG_LASTVEC: n.rdat = s.lastVec;
            REG_DROPS:   n.rdat = {16'h0000, s.dropCnt};
            default:     n.rdat = 32'h0000_0000;
         endcase
      end
   end

   // ***********************************************************
   // State register
   // ***********************************************************
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s.st      <= ST_IDLE;
         s.pkt     <= 32'h0000_0000;
         s.msg     <= 32'h0000_0000;
         s.sendMsg <= 1'b0;
         s.enable  <= CTRL_RST;
         s.afm     <= 1'b0;
         s.lastVec <= 32'h0000_0000;
         s.dropCnt <= 16'h0000;
         s.ack     <= 1'b0;
         s.rdat    <= 32'h0000_0000;
      end else begin
         s <= n;
      end
   end

   assign pktValid     = (s.st != ST_IDLE);
   assign pktData      = s.pkt;
   assign dat_o        = s.rdat;
   assign ack_o        = s.ack;
   assign allFrameMode = s.afm;

   // ***********************************************************
   // Assertions
   // ***********************************************************
   AST_TOP_ZERO: assert property (
      @(posedge mclk) disable iff (!nrst)
      pktValid |-> (pktData[31] == 1'b0))
      else $error("packet top bit not zero");

   AST_SHORT_TYPE: assert property (
      @(posedge mclk) disable iff (!nrst)
      (take && wordNumOk && isShort) |=> (pktData[VT_LSB +: 3] == VT_SHORT))
      else $error("short vector type not 010");

   AST_SHORT_ERR: assert property (
      @(posedge mclk) disable iff (!nrst)
      (take && wordNumOk && isShort) |=>
         (pktData[ERR_BIT] == $past(vecIn.bitErrs | vecIn.checkFail)))
      else $error("short vector error flag wrong");

   AST_LONG_INVALID: assert property (
      @(posedge mclk) disable iff (!nrst)
      (take && wordNumOk && isLong && (vecIn.wordCount == 7'h00)) |=>
         pktData[ERR_BIT])
      else $error("invalid count not flagged");

   AST_MSG_FOLLOWS: assert property (
      @(posedge mclk) disable iff (!nrst)
      (take && wordNumOk && isShort && vecIn.longAddr && !errFlag) ##1
         (pktValid && pktReady) |=> (s.st == ST_MSG) &&
         (pktData[WORDNO_LSB +: 7] ==
          $past(pktData[WORDNO_LSB +: 7], 1) + WORDNO_STEP))
      else $error("message packet not after vector");

   AST_ERR_WITHHOLD: assert property (
      @(posedge mclk) disable iff (!nrst)
      ((s.st == ST_VEC) && pktData[ERR_BIT] && pktReady) |=>
         (s.st == ST_IDLE))
      else $error("message sent after errored vector");

   AST_AFM_SET: assert property (
      @(posedge mclk) disable iff (!nrst)
      (take && wordNumOk && isLong) |=> allFrameMode [*2])
      else $error("all-frame mode not entered");

   AST_UNUSED_ZERO: assert property (
      @(posedge mclk) disable iff (!nrst)
      (s.st == ST_VEC) |-> (pktData[20:19] == 2'h0) &&
         (pktData[15:14] == 2'h0))
      else $error("unused vector bits not zero");

   AST_PKT_HOLD: assert property (
      @(posedge mclk) disable iff (!nrst)
      (pktValid && !pktReady) |=> pktValid && $stable(pktData))
      else $error("packet changed while stalled");

   AST_WB_ACK: assert property (
      @(posedge mclk) disable iff (!nrst)
      (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
      else $error("bus ack not one cycle after request");

   AST_WORDNUM_REFUSE: assert property (
      @(posedge mclk) disable iff (!nrst)
      (take && !wordNumOk) |=> !pktValid)
      else $error("out of range word number not refused");

   AST_WORDNUM_FIELD: assert property (
      @(posedge mclk) disable iff (!nrst)
      (take && wordNumOk && (isShort || isLong)) |=>
         (pktData[WORDNO_LSB +: 7] == $past(vecIn.vectorWordNumber)))
      else $error("word number field wrong");

   AST_PHASE_FIELD: assert property (
      @(posedge mclk) disable iff (!nrst)
      (take && wordNumOk && (isShort || isLong)) |=>
         (pktData[PH_LSB +: 2] == $past(vecIn.phase)))
      else $error("phase field wrong");

   AST_NUMERIC_DATA: assert property (
      @(posedge mclk) disable iff (!nrst)
      (take && wordNumOk && isShort && (vecIn.msgType == MT_NUM)) |=>
         (pktData[DATA_LSB +: 12] == $past(vecIn.data)))
      else $error("numeric data bits altered");

   AST_TONE8_DATA: assert property (
      @(posedge mclk) disable iff (!nrst)
      (take && wordNumOk && isShort && (vecIn.msgType == MT_TONE8)) |=>
         (pktData[DATA_LSB +: 12] == {9'h000, $past(vecIn.data[2:0])}))
      else $error("tone source data wrong");

   AST_TONEN_DATA: assert property (
      @(posedge mclk) disable iff (!nrst)
      (take && wordNumOk && isShort && (vecIn.msgType == MT_TONEN)) |=>
         (pktData[DATA_LSB +: 12] == {2'h0, $past(vecIn.data[9:0])}))
      else $error("numbered tone data wrong");

   AST_SPARE_TYPE: assert property (
      @(posedge mclk) disable iff (!nrst)
      (take && wordNumOk && isShort && (vecIn.msgType == 2'h3)) |=>
         (pktData[0 +: 2] == 2'h3) &&
         (pktData[DATA_LSB +: 12] == $past(vecIn.data)))
      else $error("spare message type not passed");

   AST_LONG_FIELDS: assert property (
      @(posedge mclk) disable iff (!nrst)
      (take && wordNumOk && isLong) |=>
         (pktData[CNT_LSB +: 7] == $past(vecIn.wordCount)) &&
         (pktData[0 +: 7] == $past(vecIn.startWord)))
      else $error("long vector count or start wrong");

   AST_LONG_TYPE: assert property (
      @(posedge mclk) disable iff (!nrst)
      (take && wordNumOk && isLong) |=>
         ((pktData[VT_LSB +: 3] == VT_SECURE) ||
          (pktData[VT_LSB +: 3] == VT_ALPHA) ||
          (pktData[VT_LSB +: 3] == VT_HEXBIN)))
      else $error("long vector type code wrong");

   AST_COUNT_RANGE: assert property (
      @(posedge mclk) disable iff (!nrst)
      (take && wordNumOk && isLong && (vecIn.wordCount > CNT_MAX)) |=>
         pktData[ERR_BIT])
      else $error("count above range not flagged");

   AST_START_RANGE: assert property (
      @(posedge mclk) disable iff (!nrst)
      (take && wordNumOk && isLong && (vecIn.startWord > START_MAX)) |=>
         pktData[ERR_BIT])
      else $error("start above range not flagged");

   AST_MSG_PHASE: assert property (
      @(posedge mclk) disable iff (!nrst)
      ((s.st == ST_VEC) && s.sendMsg && pktReady) |=> (s.st == ST_MSG) &&
         (pktData[PH_LSB +: 2] == $past(pktData[PH_LSB +: 2])))
      else $error("message packet phase differs");

   AST_AFM_HOLD: assert property (
      @(posedge mclk) disable iff (!nrst)
      (!allFrameMode && !(take && wordNumOk && isLong)) |=> !allFrameMode)
      else $error("all-frame mode set without long vector");

endmodule : pvf_formatter

// *** hdl/pvf_pkg.sv ***
// Package of the vector packet formatter: packet field layout, vector
// type codes, legal ranges, register map and the state record types.
// Assumes a single clock domain and a classic Wishbone register port.
package pvf_pkg;

   // ***********************************************************
   // Packet field layout
   // ***********************************************************
   localparam int  WORDNO_LSB = 24;
   localparam int  ERR_BIT    = 23;
   localparam int  PH_LSB     = 21;
   localparam int  VT_LSB     = 16;
   localparam int  DATA_LSB   = 2;
   localparam int  CNT_LSB    = 7;
   localparam int  INFO_W     = 21;

   // ***********************************************************
   // Vector type codes and legal ranges
   // ***********************************************************
   localparam logic [2:0] VT_SHORT  = 3'h2;
   localparam logic [2:0] VT_SECURE = 3'h0;
   localparam logic [2:0] VT_ALPHA  = 3'h5;
   localparam logic [2:0] VT_HEXBIN = 3'h6;
   localparam logic [1:0] MT_NUM    = 2'h0;
   localparam logic [1:0] MT_TONE8  = 2'h1;
   localparam logic [1:0] MT_TONEN  = 2'h2;
   localparam logic [6:0] WORDNO_MIN = 7'h02;
   localparam logic [6:0] WORDNO_MAX = 7'h57;
   localparam logic [6:0] CNT_MIN   = 7'h01;
   localparam logic [6:0] CNT_MAX   = 7'h55;
   localparam logic [6:0] START_MIN = 7'h03;
   localparam logic [6:0] START_MAX = 7'h57;
   localparam logic [6:0] WORDNO_STEP = 7'h01;
   localparam logic [11:0] MASK_TONE8 = 12'h007;
   localparam logic [11:0] MASK_TONEN = 12'h3ff;

   // ***********************************************************
   // Register map (byte addresses) and reset values
   // ***********************************************************
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_STATUS  = 8'h04;
   localparam logic [7:0]  REG_AFMCLR  = 8'h08;
   localparam logic [7:0]  REG_LASTVEC = 8'h0c;
   localparam logic [7:0]  REG_DROPS   = 8'h10;
   localparam logic        CTRL_RST    = 1'h1;
   localparam logic [15:0] DROP_ONE    = 16'h0001;
   localparam logic [15:0] DROP_MAX    = 16'hffff;

   // ***********************************************************
   // Types
   // ***********************************************************
   typedef enum logic [1:0] {ST_IDLE, ST_VEC, ST_MSG} pvf_fsm_t;

   typedef struct packed {
      logic [6:0]  vectorWordNumber;
      logic [1:0]  phase;
      logic [2:0]  vType;
      logic        bitErrs;
      logic        checkFail;
      logic        longAddr;
      logic        netAddr;
      logic [1:0]  msgType;
      logic [11:0] data;
      logic [6:0]  wordCount;
      logic [6:0]  startWord;
      logic [20:0] msgInfo;
      logic        msgErr;
   } pvf_vec_t;

   typedef struct packed {
      pvf_fsm_t    st;
      logic [31:0] pkt;
      logic [31:0] msg;
      logic        sendMsg;
      logic        enable;
      logic        afm;
      logic [31:0] lastVec;
      logic [15:0] dropCnt;
      logic        ack;
      logic [31:0] rdat;
   } pvf_state_t;

endpackage : pvf_pkg

// *** sim/pvf_host_model.sv ***
// Host side model: takes packets from the formatter into a queue.
// Assumes mclk and nrst of the bench; slow makes it stall every
// other cycle.
`timescale 1ns/10ps
module pvf_host_model (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        nrst,
   // Packet stream
   input  wire logic        pktValid,
   input  wire logic [31:0] pktData,
   output logic             pktReady,
   // Test control
   input  wire logic        slow
);
   logic [31:0] got[$];
   logic        tog;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tog <= 1'b0;
      end else begin
         tog <= ~tog;
         if (pktValid && pktReady) begin
            got.push_back(pktData);
         end
      end
   end

   assign pktReady = nrst && (!slow || tog);
endmodule : pvf_host_model

// *** sim/tb_pager_vector_packet_formatter.sv ***
// Bench of the vector packet formatter: short, long and refused
// vectors and the register port. Assumes pvf_host_model as sink.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
   $display("[FAIL] %0t mismatch got %h exp %h", $time, (a), (b)); \
   end end
module tb_pager_vector_packet_formatter
   import pvf_pkg::*;
;
   // ***************************************************
   // Signals and instances
   // ***************************************************
   logic        mclk = 1'b0, nrst = 1'b0, vecValid = 1'b0, slow = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'hf;
   logic [31:0] wdat = 32'h0;
   logic        vecReady, pktValid, pktReady, ack, afm;
   logic [31:0] pktData, rdat, q;
   pvf_vec_t    vecIn = '0;
   int          errors = 0, checked = 0, cycles = 0;

   pvf_formatter u_pvf_formatter (.mclk(mclk), .nrst(nrst),
      .vecValid(vecValid), .vecIn(vecIn), .vecReady(vecReady),
      .pktValid(pktValid), .pktReady(pktReady), .pktData(pktData),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .allFrameMode(afm));
   pvf_host_model u_pvf_host_model (.mclk(mclk), .nrst(nrst),
      .pktValid(pktValid), .pktData(pktData), .pktReady(pktReady),
      .slow(slow));

   always #4 mclk = ~mclk;

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         report_and_stop();
      end
   end

   // ***************************************************
   // Shared tasks
   // ***************************************************
   task report_and_stop();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop

   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do @(posedge mclk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk);
   endtask : wb

   task run(input pvf_vec_t v, input logic drop);
      logic [31:0] m;
      logic [11:0] d;
      logic        e, lng;
      int          n, k;
      lng = v.vType != 3'h2;
      d = v.msgType == 2'h1 ? v.data & 12'h007 :
          v.msgType == 2'h2 ? v.data & 12'h3ff : v.data;
      e = v.bitErrs | v.checkFail | (lng && (v.wordCount < 7'h01 ||
          v.wordCount > 7'h55 || v.startWord < 7'h03 ||
          v.startWord > 7'h57));
      n = drop ? 0 : (v.longAddr && !e) ? 2 : 1;
      m = (lng || (v.msgType == 2'h0 && !v.netAddr)) ?
          {11'h0, v.msgInfo} : 32'h0;
      vecValid <= 1'b1;
      vecIn    <= v;
      do @(posedge mclk); while (vecReady !== 1'b1);
      vecValid <= 1'b0;
      k = 0;
      while (u_pvf_host_model.got.size() < n && k < 40) begin
         @(posedge mclk);
         k++;
      end
      repeat (6) @(posedge mclk);
      `CHK(u_pvf_host_model.got.size(), n)
      if (n > 0) `CHK(u_pvf_host_model.got[0], {1'b0, v.vectorWordNumber, e,
         v.phase, 2'h0, v.vType, 2'h0, lng ? {v.wordCount, v.startWord} :
         {d, v.msgType}})
      if (n > 1) `CHK(u_pvf_host_model.got[1], {1'b0, v.vectorWordNumber +
         7'h01, v.msgErr, v.phase, m[20:0]})
      u_pvf_host_model.got.delete();
   endtask : run

   // ***************************************************
   // Scenarios
   // ***************************************************
   task t_regs();
      wb(1'b0, REG_CTRL, 32'h0);
      `CHK(q[0], 1'b1)
      wb(1'b0, REG_STATUS, 32'h0);
      `CHK(q[0], 1'b0)
      wb(1'b0, 8'h14, 32'h0);
      `CHK(q, 32'h0)
      wb(1'b1, REG_CTRL, 32'h0);
      `CHK(vecReady, 1'b0)
      wb(1'b1, REG_CTRL, 32'h1);
   endtask : t_regs

   task t_short();
      pvf_vec_t v;
      for (int i = 0; i < 5; i++) begin
         v = '0;
         slow <= i[0];
         v.vectorWordNumber = i[0] ? 7'h57 : 7'h02;
         v.phase = i[1:0];
         v.vType = 3'h2;
         v.msgType = i[1:0];
         v.netAddr = i == 4;
         v.data = 12'hfff;
         v.longAddr = 1'b1;
         v.msgInfo = 21'h1abcde;
         v.msgErr = i[0];
         run(v, 1'b0);
      end
      v.bitErrs = 1'b1;
      run(v, 1'b0);
      v.bitErrs = 1'b0;
      v.checkFail = 1'b1;
      run(v, 1'b0);
   endtask : t_short

   task t_long();
      pvf_vec_t   v;
      logic [2:0] vt[4] = '{3'h0, 3'h5, 3'h6, 3'h5};
      logic [6:0] cn[4] = '{7'h01, 7'h55, 7'h00, 7'h56};
      logic [6:0] st[4] = '{7'h03, 7'h57, 7'h02, 7'h58};
      for (int i = 0; i < 4; i++) begin
         v = '0;
         v.vectorWordNumber = 7'h10;
         v.phase = i[1:0];
         v.vType = vt[i];
         v.wordCount = cn[i];
         v.startWord = st[i];
         v.longAddr = 1'b1;
         v.msgInfo = 21'h0f0f0f;
         run(v, 1'b0);
         `CHK(afm, 1'b1)
         wb(1'b1, REG_AFMCLR, 32'h1);
         `CHK(afm, 1'b0)
      end
   endtask : t_long

   task t_drop();
      pvf_vec_t v;
      v = '0;
      v.vType = 3'h2;
      v.vectorWordNumber = 7'h01;
      run(v, 1'b1);
      v.vectorWordNumber = 7'h58;
      run(v, 1'b1);
      v.vectorWordNumber = 7'h02;
      v.vType = 3'h1;
      run(v, 1'b1);
      wb(1'b0, REG_DROPS, 32'h0);
      `CHK(q[15:0], 16'h0003)
   endtask : t_drop

   initial begin
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      t_regs();
      t_short();
      t_long();
      t_drop();
      report_and_stop();
   end
endmodule : tb_pager_vector_packet_formatter
